/* test/lrxm_line_model.sv */
`timescale 1ns/10ps
module lrxm_line_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [15:0] pat,
  input wire logic [4:0] patLen,
  input wire logic [7:0] flipEvery,
  output logic rxClk,
  output logic rxData
);
  logic [2:0] ph;
  logic [4:0] idx;
  logic [7:0] cnt;
  logic flip;
  assign flip = (flipEvery != 8'h00) && (cnt == flipEvery - 8'h01);
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph <= 3'h0;
      idx <= 5'h00;
      cnt <= 8'h00;
      rxClk <= 1'b0;
      rxData <= 1'b0;
    end
    else if (!run)
    begin
      // Clock stands still between frames; undriven data keeps toggling
      ph <= 3'h0;
      idx <= 5'h00;
      rxClk <= 1'b0;
      rxData <= ~rxData;
    end
    else
    begin
      ph <= ph + 3'h1;
      rxClk <= (ph >= 3'h3) && (ph != 3'h7);
      if (ph == 3'h0)
      begin
        rxData <= pat[5'h0f - idx] ^ flip;
        idx <= (idx + 5'h01 >= patLen) ? 5'h00 : idx + 5'h01;
        cnt <= flip ? 8'h00 : cnt + 8'h01;
      end
    end
  end
endmodule : lrxm_line_model

/* test/tb.sv */
`timescale 1ns/10ps
module tb;
  import lrxm_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  lrxm_reg_req_type regReq = '0;
  logic [7:0] rdData;
  logic lineStandardSelect = 1'b0;
  logic txLoopCodeEnable = 1'b0;
  logic autoRemoteLoopEnable = 1'b0;
  logic rxClkPin;
  logic rxDataPin;
  logic substCodewordHit = 1'b0;
  logic carrierLoss = 1'b0;
  logic unframedAllOnes = 1'b0;
  logic [7:0] jitterFifoFill = 8'h10;
  logic [3:0] rxLevel = 4'ha;
  logic txBitStrobe = 1'b0;
  logic txLoopBit;
  logic autoRemoteLoopActive;
  logic run = 1'b0;
  logic [15:0] pat = 16'h0000;
  logic [4:0] patLen = 5'h01;
  logic [7:0] flipEvery = 8'h00;
  logic [7:0] got;
  int errTotal = 0;
  int samplesChecked = 0;
  int cycles = 0;
  always #20 mclk = ~mclk;
  lrxm_loop_monitor #(.E1_BITS_PER_SEC(200), .T1_BITS_PER_SEC(200), .E1_INTEG(128),
    .T1_INTEG(128)) u_lrxm_loop_monitor (.mclk(mclk), .rst_n(rst_n), .regReq(regReq),
    .rdData(rdData), .lineStandardSelect(lineStandardSelect),
    .txLoopCodeEnable(txLoopCodeEnable), .autoRemoteLoopEnable(autoRemoteLoopEnable),
    .rxClkPin(rxClkPin), .rxDataPin(rxDataPin), .substCodewordHit(substCodewordHit),
    .carrierLoss(carrierLoss), .unframedAllOnes(unframedAllOnes),
    .jitterFifoFill(jitterFifoFill), .rxLevel(rxLevel), .txBitStrobe(txBitStrobe),
    .txLoopBit(txLoopBit), .autoRemoteLoopActive(autoRemoteLoopActive));
  lrxm_line_model u_lrxm_line_model (.mclk(mclk), .rst_n(rst_n), .run(run), .pat(pat),
    .patLen(patLen), .flipEvery(flipEvery), .rxClk(rxClkPin), .rxData(rxDataPin));
  ////////////////////////////////////////////////////////////////////////////////
  task completeRun;
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : completeRun
  // Hang guard sized above the longest receive run
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 70000)
    begin
      errTotal = errTotal + 1;
      completeRun();
    end
  end
  task check(string what, logic [7:0] exp, logic [7:0] seen);
    samplesChecked = samplesChecked + 1;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      errTotal = errTotal + 1;
    end
  endtask : check
  task rd(logic [4:0] a);
    @(posedge mclk) #1;
    regReq.rdEn = 1'b1;
    regReq.addr = a;
    @(posedge mclk) #1;
    regReq.rdEn = 1'b0;
    got = rdData;
  endtask : rd
  task wr(logic [4:0] a, logic [7:0] d);
    @(posedge mclk) #1;
    regReq.wrEn = 1'b1;
    regReq.addr = a;
    regReq.wrData = d;
    @(posedge mclk) #1;
    regReq.wrEn = 1'b0;
  endtask : wr
  task sendRun(logic [15:0] p, logic [4:0] l, int n);
    pat = p;
    patLen = l;
    run = 1'b1;
    repeat (n * 8) @(posedge mclk);
    #1 run = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
  endtask : sendRun
  ////////////////////////////////////////////////////////////////////////////////
  task resetVals;
    rd(ADDR_RX_INFO_TWO);
    check("info two", 8'ha0, got & 8'hf3);
    rd(ADDR_RX_INFO_ONE);
    check("info one", 8'h00, got & 8'hfc);
    rd(ADDR_LEN_CTRL);
    check("length ctrl", REG_RESET, got);
    rd(5'h1f);
    check("unmapped", 8'h00, got);
    $display("reset values done");
  endtask : resetVals
  task zeroCase(logic std, int n, logic [7:0] exp);
    lineStandardSelect = std;
    sendRun(16'hffff, 5'h01, 1);
    sendRun(16'h0000, 5'h10, n);
    rd(ADDR_RX_INFO_ONE);
    check("zero run flags", exp, got & 8'hc0);
  endtask : zeroCase
  task zeroRun;
    zeroCase(1'b0, 3, 8'h00);
    zeroCase(1'b0, 4, 8'h80);
    zeroCase(1'b1, 7, 8'h00);
    zeroCase(1'b1, 8, 8'h80);
    zeroCase(1'b1, 15, 8'h80);
    zeroCase(1'b0, 16, 8'hc0);
    $display("zero run done");
  endtask : zeroRun
  task events;
    carrierLoss = 1'b1;
    unframedAllOnes = 1'b1;
    rd(ADDR_RX_INFO_ONE);
    @(posedge mclk) #1;
    regReq.rdEn = 1'b1;
    substCodewordHit = 1'b1;
    carrierLoss = 1'b0;
    @(posedge mclk) #1;
    regReq.rdEn = 1'b0;
    substCodewordHit = 1'b0;
    unframedAllOnes = 1'b0;
    check("old flags", 8'h00, rdData & 8'hfc);
    jitterFifoFill = 8'(JA_DEPTH - JA_MARGIN);
    @(posedge mclk) #1;
    jitterFifoFill = 8'(JA_DEPTH - JA_MARGIN - 1);
    rd(ADDR_RX_INFO_ONE);
    check("event flags", 8'h3c, got & 8'hfc);
    rd(ADDR_RX_INFO_ONE);
    check("flags cleared", 8'h00, got & 8'hfc);
    jitterFifoFill = 8'h10;
    $display("events done");
  endtask : events
  task txCase(logic [1:0] sel, logic [7:0] lo, logic [7:0] hi, int len);
    logic [15:0] p;
    p = {lo, hi};
    wr(ADDR_TX_CODE_LOW, lo);
    wr(ADDR_TX_CODE_HIGH, hi);
    wr(ADDR_LEN_CTRL, {sel, 6'h27});
    txLoopCodeEnable = 1'b1;
    for (int i = 0; i < 2 * len + 2; i++)
    begin
      @(posedge mclk) #1 txBitStrobe = 1'b1;
      @(posedge mclk) #1 txBitStrobe = 1'b0;
      check("tx bit", {7'h00, p[15 - (i % len)]}, {7'h00, txLoopBit});
    end
    txLoopCodeEnable = 1'b0;
    @(posedge mclk) #1;
    check("tx idle", 8'h00, {7'h00, txLoopBit});
  endtask : txCase
  task txAll;
    txCase(2'b00, 8'h87, 8'h00, 5);
    txCase(2'b01, 8'hb7, 8'h00, 6);
    txCase(2'b10, 8'h6d, 8'h00, 7);
    txCase(2'b11, 8'ha5, 8'h3c, 16);
    $display("transmit done");
  endtask : txAll
  task detect;
    wr(ADDR_UP_CODE_LOW, 8'h80);
    wr(ADDR_DN_CODE_LOW, 8'hff);
    wr(ADDR_DN_CODE_HIGH, 8'h00);
    wr(ADDR_LEN_CTRL, 8'h27);
    rd(ADDR_STATUS);
    flipEvery = 8'h64;
    rxLevel = 4'h3;
    pat = 16'h8000;
    patLen = 5'h05;
    run = 1'b1;
    // Over five seconds of loop-up while disabled, so a missing force-low shows
    repeat (17600) @(posedge mclk);
    #1;
    check("loop off", 8'h00, {7'h00, autoRemoteLoopActive});
    rd(ADDR_STATUS);
    check("up detect", 8'h80, got);
    rd(ADDR_RX_INFO_TWO);
    check("second tick", 8'h31, got & 8'hf3);
    rd(ADDR_RX_INFO_TWO);
    check("tick cleared", 8'h30, got & 8'hf3);
    autoRemoteLoopEnable = 1'b1;
    repeat (11200) @(posedge mclk);
    #1;
    check("loop on", 8'h01, {7'h00, autoRemoteLoopActive});
    pat = 16'hff00;
    patLen = 5'h10;
    repeat (20800) @(posedge mclk);
    #1;
    check("loop released", 8'h00, {7'h00, autoRemoteLoopActive});
    rd(ADDR_STATUS);
    rd(ADDR_STATUS);
    check("down detect", 8'h40, got);
    run = 1'b0;
    $display("detectors done");
  endtask : detect
  initial
  begin
    repeat (8) @(posedge mclk);
    #1 rst_n = 1'b1;
    resetVals();
    zeroRun();
    events();
    txAll();
    detect();
    completeRun();
  end
endmodule : tb

/* verilog/lrxm_loop_monitor.sv */
`timescale 1ns/10ps
// Contract
// - Zero-run flag latches on 4 (E1) or 8 (T1) zeros, clears on read.
// - Long-zero-run flag latches on 16 or more zeros, clears on read.
// - Substitution codeword flag latches regardless of decode mode, clears on read.
// - Carrier-loss-cleared flag latches when the alarm clears, clears on read.
// - All-ones-cleared flag latches when all-ones ends, clears on read.
// - Jitter flag latches within four bits of FIFO limit, clears on read.
// - Unassigned bits of both info registers carry no meaning; host ignores them.
// - Receive level is a real-time 4-bit code in 2.5 dB steps.
// - Auto loop indicator sets after 5 s loop-up, clears after 5 s loop-down.
// - Auto loop indicator held zero while its enable is low.
// - One-second flag latches each second of received bits, clears on read.
// - Patterns of one to eight or sixteen bits are generated and detected.
// - Loop pattern repeats on the line while transmit enable is set.
// - Two independent detectors, loop-up and loop-down, with separate lengths.
// - Detectors tolerate a bit-error rate of one per hundred bits.
// - After about 48 ms of code the matching detected bit is set.
// - Transmit length 00=5, 01=6/3, 10=7, 11=16/8/4/2/1 bits.
// - Receive length 000..110 = 1..7 bits, 111 = 16/8 bits.
// - Low code register MSB sends first; unused low bits ignored.
module lrxm_loop_monitor #(
  parameter int E1_BITS_PER_SEC = lrxm_pkg::E1_RATE_HZ,
  parameter int T1_BITS_PER_SEC = lrxm_pkg::T1_RATE_HZ,
  parameter int E1_INTEG = lrxm_pkg::E1_INTEG_BITS,
  parameter int T1_INTEG = lrxm_pkg::T1_INTEG_BITS,
  parameter int JITTER_DEPTH = lrxm_pkg::JA_DEPTH
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire lrxm_pkg::lrxm_reg_req_type regReq,
  output logic [7:0] rdData,
  input wire logic lineStandardSelect,
  input wire logic txLoopCodeEnable,
  input wire logic autoRemoteLoopEnable,
  input wire logic rxClkPin,
  input wire logic rxDataPin,
  input wire logic substCodewordHit,
  input wire logic carrierLoss,
  input wire logic unframedAllOnes,
  input wire logic [7:0] jitterFifoFill,
  input wire logic [3:0] rxLevel,
  input wire logic txBitStrobe,
  output logic txLoopBit,
  output logic autoRemoteLoopActive
);
  import lrxm_pkg::*;

  // one to seven or sixteen bits
  function automatic logic [4:0] rxCodeLen(input logic [2:0] code);
    rxCodeLen = (code == 3'h7) ? RX_LEN_MAX : {2'h0, code} + 5'h01;
  endfunction : rxCodeLen

  function automatic logic [3:0] phaseStep(input logic [3:0] ph, input logic [4:0] len,
                                           input logic [5:0] step);
    logic [5:0] s;
    s = {2'h0, ph} + step;
    if (s >= {1'b0, len})
      s = s - {1'b0, len};
    if (s >= {1'b0, len})
      s = s - {1'b0, len};
    phaseStep = s[3:0];
  endfunction : phaseStep

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bit strobe from the recovered receive clock

  logic [2:0] rxClkSync_r;
  logic [1:0] rxDataSync_r;
  logic rxBitStrobe;
  logic rxBit;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxClkSync_r <= 3'h0;
      rxDataSync_r <= 2'h0;
    end
    else
    begin
      rxClkSync_r <= {rxClkSync_r[1:0], rxClkPin};
      rxDataSync_r <= {rxDataSync_r[0], rxDataPin};
    end
  end

  assign rxBitStrobe = rxClkSync_r[1] & ~rxClkSync_r[2];
  assign rxBit = rxDataSync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers

  logic [7:0] lenCtrl_r, lenCtrl_nxt;
  logic [7:0] txCodeLow_r, txCodeLow_nxt, txCodeHigh_r, txCodeHigh_nxt;
  logic [7:0] rxCodeLow_r [2];
  logic [7:0] rxCodeHigh_r [2];
  logic [7:0] rxCodeLow_nxt [2];
  logic [7:0] rxCodeHigh_nxt [2];

  always_comb
  begin
    lenCtrl_nxt = lenCtrl_r;
    txCodeLow_nxt = txCodeLow_r;
    txCodeHigh_nxt = txCodeHigh_r;
    rxCodeLow_nxt = rxCodeLow_r;
    rxCodeHigh_nxt = rxCodeHigh_r;
    if (regReq.wrEn)
    begin
      if (regReq.addr == ADDR_LEN_CTRL)
        lenCtrl_nxt = regReq.wrData;
      else if (regReq.addr == ADDR_TX_CODE_LOW)
        txCodeLow_nxt = regReq.wrData;
      else if (regReq.addr == ADDR_TX_CODE_HIGH)
        txCodeHigh_nxt = regReq.wrData;
      else if (regReq.addr == ADDR_UP_CODE_LOW)
        rxCodeLow_nxt[0] = regReq.wrData;
      else if (regReq.addr == ADDR_UP_CODE_HIGH)
        rxCodeHigh_nxt[0] = regReq.wrData;
      else if (regReq.addr == ADDR_DN_CODE_LOW)
        rxCodeLow_nxt[1] = regReq.wrData;
      else if (regReq.addr == ADDR_DN_CODE_HIGH)
        rxCodeHigh_nxt[1] = regReq.wrData;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lenCtrl_r <= REG_RESET;
      txCodeLow_r <= REG_RESET;
      txCodeHigh_r <= REG_RESET;
      rxCodeLow_r <= '{REG_RESET, REG_RESET};
      rxCodeHigh_r <= '{REG_RESET, REG_RESET};
    end
    else
    begin
      lenCtrl_r <= lenCtrl_nxt;
      txCodeLow_r <= txCodeLow_nxt;
      txCodeHigh_r <= txCodeHigh_nxt;
      rxCodeLow_r <= rxCodeLow_nxt;
      rxCodeHigh_r <= rxCodeHigh_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loop-code transmitter

  logic [3:0] txIdx_r, txIdx_nxt;
  logic txBit_r, txBit_nxt;
  logic [4:0] txLen;
  logic [15:0] txPattern;

  always_comb
  begin
    case (lenCtrl_r[LSB_TX_LEN +: 2])
      2'h0: txLen = TX_LEN_CODE0;
      2'h1: txLen = TX_LEN_CODE1;
      2'h2: txLen = TX_LEN_CODE2;
      default: txLen = TX_LEN_CODE3;
    endcase
    // low register MSB goes out first; short lengths never reach low bits
    // lengths 8, 4, 2 and 1 rely on the host repeating the code in both registers
    txPattern = {txCodeLow_r, txCodeHigh_r};
    txIdx_nxt = txIdx_r;
    txBit_nxt = txBit_r;
    if (!txLoopCodeEnable)
    begin
      txIdx_nxt = 4'h0;
      txBit_nxt = 1'b0;
    end
    else if (txBitStrobe)
    begin
      txBit_nxt = txPattern[4'hf - txIdx_r];
      txIdx_nxt = phaseStep(txIdx_r, txLen, 6'h01);
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txIdx_r <= 4'h0;
      txBit_r <= 1'b0;
    end
    else
    begin
      txIdx_r <= txIdx_nxt;
      txBit_r <= txBit_nxt;
    end
  end

  assign txLoopBit = txBit_r;

  chk_tx_idle_low: assert property (@(posedge mclk) disable iff (!rst_n)
    !txLoopCodeEnable |=> !txLoopBit && txIdx_r == 4'h0)
    else $error("loop bit driven while transmit disabled");

  ////////////////////////////////////////////////////////////////////////////
  // Loop-up (0) and loop-down (1) detectors

  logic [3:0] phase_r [2];
  logic [3:0] phase_nxt [2];
  logic [CNT_W-1:0] bitCnt_r [2];
  logic [CNT_W-1:0] bitCnt_nxt [2];
  logic [CNT_W-1:0] errCnt_r [2];
  logic [CNT_W-1:0] errCnt_nxt [2];
  logic [1:0] codeHit_r, codeHit_nxt;
  logic [CNT_W-1:0] integLimit, errLimit;

  assign integLimit = lineStandardSelect ? CNT_W'(T1_INTEG - 1) : CNT_W'(E1_INTEG - 1);
  assign errLimit = lineStandardSelect ? CNT_W'(T1_INTEG / ERR_DIV) : CNT_W'(E1_INTEG / ERR_DIV);

  always_comb
  begin
    logic [4:0] len;
    logic [15:0] pat;
    logic [CNT_W-1:0] errNow;
    len = 5'h00;
    pat = 16'h0000;
    errNow = '0;
    phase_nxt = phase_r;
    bitCnt_nxt = bitCnt_r;
    errCnt_nxt = errCnt_r;
    codeHit_nxt = codeHit_r;
    // each detector with its own code and length field
    for (int d = 0; d < 2; d++)
    begin
      len = rxCodeLen(lenCtrl_r[(d == 0 ? LSB_UP_LEN : LSB_DN_LEN) +: 3]);
      pat = {rxCodeLow_r[d], rxCodeHigh_r[d]};
      if (rxBitStrobe)
      begin
        // count mismatches over a window instead of needing a clean run
        errNow = errCnt_r[d] + CNT_W'(rxBit != pat[4'hf - phase_r[d]]);
        phase_nxt[d] = phaseStep(phase_r[d], len, 6'h01);
        bitCnt_nxt[d] = bitCnt_r[d] + 1'b1;
        errCnt_nxt[d] = errNow;
        if (bitCnt_r[d] == CNT_W'(HUNT_BITS - 1) && errNow > CNT_W'(HUNT_ERR))
        begin
          // Misaligned: slip one bit and restart, so each wrong phase costs only 64 bits
          phase_nxt[d] = phaseStep(phase_r[d], len, 6'h02);
          bitCnt_nxt[d] = '0;
          errCnt_nxt[d] = '0;
          codeHit_nxt[d] = 1'b0;
        end
        // decision at the end of each integration window
        else if (bitCnt_r[d] >= integLimit)
        begin
          codeHit_nxt[d] = (errNow <= errLimit);
          if (errNow > errLimit)
            phase_nxt[d] = phaseStep(phase_r[d], len, 6'h02);
          bitCnt_nxt[d] = '0;
          errCnt_nxt[d] = '0;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_r <= '{4'h0, 4'h0};
      bitCnt_r <= '{'0, '0};
      errCnt_r <= '{'0, '0};
      codeHit_r <= 2'h0;
    end
    else
    begin
      phase_r <= phase_nxt;
      bitCnt_r <= bitCnt_nxt;
      errCnt_r <= errCnt_nxt;
      codeHit_r <= codeHit_nxt;
    end
  end

  chk_hit_window_end: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(codeHit_r[0]) |-> $past(bitCnt_r[0]) >= integLimit && bitCnt_r[0] == '0)
    else $error("loop-up hit outside a window boundary");

  ////////////////////////////////////////////////////////////////////////////
  // Receive monitor flags, one-second timer and auto loop indicator

  logic [4:0] zeroRun_r, zeroRun_nxt;
  logic [7:0] infoFlags_r, infoFlags_nxt;
  logic carrierDly_r, allOnesDly_r;
  logic [CNT_W-1:0] secCnt_r, secCnt_nxt;
  logic secFlag_r, secFlag_nxt;
  logic [1:0] detSticky_r, detSticky_nxt;
  logic [2:0] upSec_r, upSec_nxt, dnSec_r, dnSec_nxt;
  logic autoLoop_r, autoLoop_nxt;
  logic readInfoOne, readInfoTwo, readStatus, secEvent, jitterNear;
  logic [7:0] infoEvents;
  logic [CNT_W-1:0] secLimit;
  logic [4:0] zeroThr;

  assign readInfoOne = regReq.rdEn && regReq.addr == ADDR_RX_INFO_ONE;
  assign readInfoTwo = regReq.rdEn && regReq.addr == ADDR_RX_INFO_TWO;
  assign readStatus = regReq.rdEn && regReq.addr == ADDR_STATUS;
  assign secLimit = lineStandardSelect ? CNT_W'(T1_BITS_PER_SEC - 1) :
                    CNT_W'(E1_BITS_PER_SEC - 1);
  assign secEvent = rxBitStrobe && secCnt_r >= secLimit;
  assign zeroThr = lineStandardSelect ? ZERO_RUN_T1 : ZERO_RUN_E1;
  // near either end of the FIFO
  assign jitterNear = ({1'b0, jitterFifoFill} + 9'(JA_MARGIN) >= 9'(JITTER_DEPTH)) ||
                      (jitterFifoFill <= 8'(JA_MARGIN));

  always_comb
  begin
    zeroRun_nxt = zeroRun_r;
    infoEvents = 8'h00;
    if (rxBitStrobe)
      zeroRun_nxt = rxBit ? 5'h00 : (zeroRun_r == ZERO_RUN_LONG ? zeroRun_r : zeroRun_r + 5'h01);
    infoEvents[BIT_ZERO_RUN] = rxBitStrobe && !rxBit && zeroRun_nxt == zeroThr;
    infoEvents[BIT_LONG_ZERO_RUN] = rxBitStrobe && !rxBit && zeroRun_nxt == ZERO_RUN_LONG;
    // codeword seen regardless of decode mode
    infoEvents[BIT_SUBST_CODEWORD] = substCodewordHit;
    infoEvents[BIT_CARRIER_CLEARED] = carrierDly_r && !carrierLoss;
    infoEvents[BIT_ALL_ONES_CLEARED] = allOnesDly_r && !unframedAllOnes;
    infoEvents[BIT_JITTER_NEAR] = jitterNear;
    infoFlags_nxt = (readInfoOne ? 8'h00 : infoFlags_r) | infoEvents;
    // tick on each second of received bits
    secCnt_nxt = secCnt_r;
    if (rxBitStrobe)
      secCnt_nxt = secEvent ? '0 : secCnt_r + 1'b1;
    secFlag_nxt = (readInfoTwo ? 1'b0 : secFlag_r) | secEvent;
    // latched detected bits, set wins over the status read
    detSticky_nxt = (readStatus ? 2'h0 : detSticky_r) | codeHit_nxt;
    // count whole seconds of continuous detection
    upSec_nxt = upSec_r;
    dnSec_nxt = dnSec_r;
    autoLoop_nxt = autoLoop_r;
    if (secEvent)
    begin
      upSec_nxt = !codeHit_r[0] ? 3'h0 : (upSec_r == 3'(AUTO_LOOP_SEC) ? upSec_r : upSec_r + 3'h1);
      dnSec_nxt = !codeHit_r[1] ? 3'h0 : (dnSec_r == 3'(AUTO_LOOP_SEC) ? dnSec_r : dnSec_r + 3'h1);
    end
    if (dnSec_nxt == 3'(AUTO_LOOP_SEC))
      autoLoop_nxt = 1'b0;
    else if (upSec_nxt == 3'(AUTO_LOOP_SEC))
      autoLoop_nxt = 1'b1;
    // disabled circuitry forces the indicator low
    if (!autoRemoteLoopEnable)
    begin
      upSec_nxt = 3'h0;
      dnSec_nxt = 3'h0;
      autoLoop_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      zeroRun_r <= 5'h00;
      infoFlags_r <= 8'h00;
      carrierDly_r <= 1'b0;
      allOnesDly_r <= 1'b0;
      secCnt_r <= '0;
      secFlag_r <= 1'b0;
      detSticky_r <= 2'h0;
      upSec_r <= 3'h0;
      dnSec_r <= 3'h0;
      autoLoop_r <= 1'b0;
    end
    else
    begin
      zeroRun_r <= zeroRun_nxt;
      infoFlags_r <= infoFlags_nxt;
      carrierDly_r <= carrierLoss;
      allOnesDly_r <= unframedAllOnes;
      secCnt_r <= secCnt_nxt;
      secFlag_r <= secFlag_nxt;
      detSticky_r <= detSticky_nxt;
      upSec_r <= upSec_nxt;
      dnSec_r <= dnSec_nxt;
      autoLoop_r <= autoLoop_nxt;
    end
  end

  assign autoRemoteLoopActive = autoLoop_r;

  chk_zero_run_set: assert property (@(posedge mclk) disable iff (!rst_n)
    rxBitStrobe && !rxBit && zeroRun_r == zeroThr - 5'h01 |=> infoFlags_r[BIT_ZERO_RUN])
    else $error("zero-run flag missed at threshold");

  chk_long_zero_set: assert property (@(posedge mclk) disable iff (!rst_n)
    rxBitStrobe && !rxBit && zeroRun_r == 5'h0f |=> infoFlags_r[BIT_LONG_ZERO_RUN])
    else $error("long zero-run flag missed");

  chk_read_keeps_event: assert property (@(posedge mclk) disable iff (!rst_n)
    readInfoOne && substCodewordHit |=> infoFlags_r[BIT_SUBST_CODEWORD])
    else $error("event lost in the read cycle");

  chk_read_clears: assert property (@(posedge mclk) disable iff (!rst_n)
    readInfoOne && !jitterNear |=> !infoFlags_r[BIT_JITTER_NEAR])
    else $error("jitter flag not cleared by read");

  chk_carrier_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(carrierLoss) |-> ##1 infoFlags_r[BIT_CARRIER_CLEARED])
    else $error("carrier-loss clear not latched");

  chk_sec_tick: assert property (@(posedge mclk) disable iff (!rst_n)
    secEvent |=> secFlag_r && secCnt_r == '0)
    else $error("one-second tick not latched");

  chk_auto_loop_off: assert property (@(posedge mclk) disable iff (!rst_n)
    !autoRemoteLoopEnable |=> !autoRemoteLoopActive)
    else $error("auto loop indicator set while disabled");

  chk_auto_loop_rise: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(autoRemoteLoopActive) |-> $past(secEvent) && upSec_r == 3'(AUTO_LOOP_SEC))
    else $error("auto loop indicator rose without five seconds");

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data registered one cycle after the read strobe

  logic [7:0] rdData_r, rdData_nxt;

  always_comb
  begin
    rdData_nxt = rdData_r;
    if (regReq.rdEn)
    begin
      if (regReq.addr == ADDR_RX_INFO_ONE)
        rdData_nxt = infoFlags_r;
      else if (regReq.addr == ADDR_RX_INFO_TWO)
        rdData_nxt = {rxLevel, 2'h0, autoLoop_r, secFlag_r};
      else if (regReq.addr == ADDR_STATUS)
        rdData_nxt = {detSticky_r[0], detSticky_r[1], 6'h00};
      else if (regReq.addr == ADDR_LEN_CTRL)
        rdData_nxt = lenCtrl_r;
      else if (regReq.addr == ADDR_TX_CODE_LOW)
        rdData_nxt = txCodeLow_r;
      else if (regReq.addr == ADDR_TX_CODE_HIGH)
        rdData_nxt = txCodeHigh_r;
      else if (regReq.addr == ADDR_UP_CODE_LOW)
        rdData_nxt = rxCodeLow_r[0];
      else if (regReq.addr == ADDR_UP_CODE_HIGH)
        rdData_nxt = rxCodeHigh_r[0];
      else if (regReq.addr == ADDR_DN_CODE_LOW)
        rdData_nxt = rxCodeLow_r[1];
      else if (regReq.addr == ADDR_DN_CODE_HIGH)
        rdData_nxt = rxCodeHigh_r[1];
      else
        rdData_nxt = 8'h00;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdData_r <= 8'h00;
    else
      rdData_r <= rdData_nxt;
  end

  assign rdData = rdData_r;

  chk_level_read: assert property (@(posedge mclk) disable iff (!rst_n)
    readInfoTwo |=> rdData[7:4] == $past(rxLevel) && rdData[3:2] == 2'h0)
    else $error("receive level read back wrong");

endmodule : lrxm_loop_monitor

/* verilog/lrxm_pkg.sv */
package lrxm_pkg;

  // Register addresses on the 8-bit register port
  localparam logic [4:0] ADDR_STATUS = 5'h06;
  localparam logic [4:0] ADDR_RX_INFO_ONE = 5'h08;
  localparam logic [4:0] ADDR_RX_INFO_TWO = 5'h09;
  localparam logic [4:0] ADDR_LEN_CTRL = 5'h0a;
  localparam logic [4:0] ADDR_TX_CODE_LOW = 5'h0b;
  localparam logic [4:0] ADDR_TX_CODE_HIGH = 5'h0c;
  localparam logic [4:0] ADDR_UP_CODE_LOW = 5'h0d;
  localparam logic [4:0] ADDR_UP_CODE_HIGH = 5'h0e;
  localparam logic [4:0] ADDR_DN_CODE_LOW = 5'h0f;
  localparam logic [4:0] ADDR_DN_CODE_HIGH = 5'h10;

  // Field positions
  localparam int BIT_ZERO_RUN = 7;
  localparam int BIT_LONG_ZERO_RUN = 6;
  localparam int BIT_SUBST_CODEWORD = 5;
  localparam int BIT_CARRIER_CLEARED = 4;
  localparam int BIT_ALL_ONES_CLEARED = 3;
  localparam int BIT_JITTER_NEAR = 2;
  localparam int LSB_RX_LEVEL = 4;
  localparam int BIT_AUTO_LOOP = 1;
  localparam int BIT_ONE_SECOND = 0;
  localparam int BIT_LOOP_UP = 7;
  localparam int BIT_LOOP_DOWN = 6;
  localparam int LSB_TX_LEN = 6;
  localparam int LSB_UP_LEN = 3;
  localparam int LSB_DN_LEN = 0;

  // Reset value of every writable register
  localparam logic [7:0] REG_RESET = 8'h00;

  // Zero-run thresholds in bits
  localparam logic [4:0] ZERO_RUN_E1 = 5'h04;
  localparam logic [4:0] ZERO_RUN_T1 = 5'h08;
  localparam logic [4:0] ZERO_RUN_LONG = 5'h10;

  // Jitter FIFO margin in bits
  localparam int JA_MARGIN = 4;
  localparam int JA_DEPTH = 32;

  // Line rates and timing, counted in received bits
  localparam int E1_RATE_HZ = 2048000;
  localparam int T1_RATE_HZ = 1544000;
  localparam int INTEG_MS = 48;
  localparam int MS_PER_SEC = 1000;
  localparam int E1_INTEG_BITS = E1_RATE_HZ / MS_PER_SEC * INTEG_MS;
  localparam int T1_INTEG_BITS = T1_RATE_HZ / MS_PER_SEC * INTEG_MS;
  localparam int AUTO_LOOP_SEC = 5;
  localparam int CNT_W = 21;

  // Error budget: window errors allowed are window / ERR_DIV (twice 1e-2)
  localparam int ERR_DIV = 50;
  // Early alignment check at the start of each window
  localparam int HUNT_BITS = 64;
  localparam int HUNT_ERR = 8;

  // Transmit lengths per selector code, and the longest receive length
  localparam logic [4:0] TX_LEN_CODE0 = 5'h05;
  localparam logic [4:0] TX_LEN_CODE1 = 5'h06;
  localparam logic [4:0] TX_LEN_CODE2 = 5'h07;
  localparam logic [4:0] TX_LEN_CODE3 = 5'h10;
  localparam logic [4:0] RX_LEN_MAX = 5'h10;

  typedef struct packed {
    logic rdEn;
    logic wrEn;
    logic [4:0] addr;
    logic [7:0] wrData;
  } lrxm_reg_req_type;

endpackage : lrxm_pkg
